/* shared/plltmr_pkg.sv */
// Package with register map, field layout and reset values of the lock timer block.
package plltmr_pkg;
    localparam logic [6:0] PLLTMR_MODE_ADDR = 7'h58;
    localparam int PLLTMR_STATUS_BIT = 0;
    localparam int PLLTMR_PLLSEL_BIT = 1;
    localparam int PLLTMR_FORCE_BIT = 2;
    localparam int PLLTMR_CNT_LSB = 3;
    localparam int PLLTMR_CNT_MSB = 10;
    localparam int PLLTMR_FRAC_BIT = 11;
    localparam int PLLTMR_MUL_LSB = 12;
    localparam int PLLTMR_MUL_MSB = 15;
    localparam logic [3:0] PLLTMR_DIV_LAST = 4'hF;
    localparam logic [3:0] PLLTMR_MUL_RESET = 4'hF;
    localparam logic [7:0] PLLTMR_CNT_RESET = 8'h00;
    localparam logic [3:0] PLLTMR_PRESCALE_LAST = 4'hF;
    localparam logic [3:0] PLLTMR_MUL_BYPASS = 4'hF;
    localparam logic [15:0] PLLTMR_RESET_WORD = 16'hF003;
    localparam logic [7:0] PLLTMR_MULT_RESET = 8'h04;
    // Multiplier in quarter units: output = ref * mult_q / 4.
    typedef logic [7:0] plltmr_mult_t;
    typedef enum logic [1:0] {
        PLLTMR_DIV = 2'b00,
        PLLTMR_LOCK = 2'b01,
        PLLTMR_PLL = 2'b10
    } plltmr_state_t;
endpackage

/* rtl/plltmr_top.sv */
// Clock mode register, lock timer and core clock source selection.
//
// Contract
// R1 - The lock timer is a down-counter loaded from the lock-count field that runs to zero.
// R2 - The preset and counter are eight bits, taking any value 0 to 255.
// R3 - The counter steps down once every sixteen reference clocks via a divide-by-16 enable.
// R4 - A change from divide mode to PLL mode starts the lock timer.
// R5 - The core stays on divide mode while counting and moves to the PLL only at zero.
// R6 - Software programs the count as lockup time over sixteen reference periods.
// R7 - Software uses the lockup time for the target frequency, 16 us to 35 us.
// R8 - The clock mode register is at data address 58h.
// R9 - The lock-count field occupies bits 10 to 3 of the clock mode register.
// R10 - The multiplier follows the divide, integer, bypass and fractional table.
// R11 - The oscillator runs when the force-on bit or the PLL-select bit is high.
// R12 - Bit 0 reads 0 in divide mode and 1 in PLL mode and is read-only.
// R13 - A write setting PLL-select while in divide mode loads the counter and starts it.
`timescale 1ns/100ps
module plltmr_top
    import plltmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] mmr_addr,
    input wire logic mmr_wr,
    input wire logic mmr_rd,
    input wire logic [15:0] mmr_wdata,
    output logic [15:0] mmr_rdata,
    output logic vco_run,
    output logic core_on_pll,
    output plltmr_pkg::plltmr_mult_t mult_q,
    output logic [7:0] lock_count_now
);
    import plltmr_pkg::*;

    // Register image and control state, all held in one set of flip-flops.
    typedef struct packed {
        logic [3:0] multiply_field;
        logic fraction_select_bit;
        logic [7:0] lock_count_field;
        logic vco_force_on_bit;
        logic pll_select_bit;
        plltmr_state_t state;
        logic [7:0] cnt;
        logic [3:0] prescale;
        logic [15:0] rdata;
        logic vco;
        logic on_pll;
        plltmr_mult_t mult;
    } plltmr_regs_t;

    // Values taken on reset: PLL mode with the multiplier in bypass.
    localparam plltmr_regs_t RESET_STATE = '{
        multiply_field: PLLTMR_MUL_RESET,
        fraction_select_bit: 1'b0,
        lock_count_field: PLLTMR_CNT_RESET,
        vco_force_on_bit: 1'b0,
        pll_select_bit: 1'b1,
        state: PLLTMR_PLL,
        cnt: 8'h00,
        prescale: 4'h0,
        rdata: 16'h0000,
        vco: 1'b1,
        on_pll: 1'b1,
        mult: PLLTMR_MULT_RESET
    };

    plltmr_regs_t cur_r;
    plltmr_regs_t cur_nxt;
    logic wr_hit;
    logic rd_hit;
    logic tick;
    logic cnt_zero;
    logic dec_now;
    logic start_lock;
    logic abort_lock;
    logic [7:0] wr_count;
    logic [15:0] cur_word;

    // True when a strobe addresses the clock mode register.
    function automatic logic reg_hit(input logic strobe, input logic [6:0] addr);
        logic hit;
        hit = strobe && (addr == PLLTMR_MODE_ADDR);
        return hit;
    endfunction

    // Builds the register image; bit 0 comes from the state, never from written data.
    function automatic logic [15:0] pack_word(input plltmr_regs_t r);
        logic [15:0] w;
        w = 16'h0000;
        w[PLLTMR_MUL_MSB:PLLTMR_MUL_LSB] = r.multiply_field;
        w[PLLTMR_FRAC_BIT] = r.fraction_select_bit;
        w[PLLTMR_CNT_MSB:PLLTMR_CNT_LSB] = r.lock_count_field; // [R9]
        w[PLLTMR_FORCE_BIT] = r.vco_force_on_bit;
        w[PLLTMR_PLLSEL_BIT] = r.pll_select_bit;
        w[PLLTMR_STATUS_BIT] = (r.state == PLLTMR_PLL); // [R12]
        return w;
    endfunction

    // Copies the writable fields of a register write into the state.
    function automatic plltmr_regs_t apply_write(input plltmr_regs_t r, input logic [15:0] d);
        plltmr_regs_t n;
        n = r;
        n.multiply_field = d[PLLTMR_MUL_MSB:PLLTMR_MUL_LSB];
        n.fraction_select_bit = d[PLLTMR_FRAC_BIT];
        n.lock_count_field = d[PLLTMR_CNT_MSB:PLLTMR_CNT_LSB]; // [R2] [R9]
        n.vco_force_on_bit = d[PLLTMR_FORCE_BIT];
        n.pll_select_bit = d[PLLTMR_PLLSEL_BIT];
        return n;
    endfunction

    // Multiplier in quarter units for the current mode and field values.
    function automatic plltmr_mult_t calc_mult(input logic pll, input logic frac,
                                               input logic [3:0] mul);
        plltmr_mult_t m;
        logic [3:0] inc;
        m = 8'h00;
        inc = mul + 4'h1;
        if (!pll) begin
            if (mul == PLLTMR_DIV_LAST) begin
                m = 8'h01;
            end else begin
                m = 8'h02;
            end
        end else if (!frac) begin
            if (mul == PLLTMR_MUL_BYPASS) begin
                m = 8'h04;
            end else begin
                m = {2'b00, inc, 2'b00};
            end
        end else if (!mul[0]) begin
            m = {3'b000, inc, 1'b0};
        end else begin
            m = {4'h0, mul};
        end
        return m;
    endfunction

    assign wr_hit = reg_hit(mmr_wr, mmr_addr); // [R8]
    assign rd_hit = reg_hit(mmr_rd, mmr_addr); // [R8]
    assign tick = (cur_r.prescale == PLLTMR_PRESCALE_LAST); // [R3]
    assign cnt_zero = (cur_r.cnt == 8'h00);
    assign dec_now = tick && !cnt_zero;
    assign wr_count = mmr_wdata[PLLTMR_CNT_MSB:PLLTMR_CNT_LSB];
    assign start_lock = wr_hit && mmr_wdata[PLLTMR_PLLSEL_BIT]; // [R4] [R13]
    assign abort_lock = wr_hit && !mmr_wdata[PLLTMR_PLLSEL_BIT];
    assign cur_word = pack_word(cur_r);

    // Next state: register writes, lock timer and core clock source.
    always_comb begin
        cur_nxt = cur_r;
        // The prescaler runs freely and restarts on a load, so the first step is a full period.
        cur_nxt.prescale = cur_r.prescale + 4'h1; // [R3]
        if (wr_hit) begin
            cur_nxt = apply_write(cur_nxt, mmr_wdata);
        end
        // Writing the PLL-select bit low from lock or PLL mode returns to divide mode.
        unique case (cur_r.state)
            PLLTMR_DIV: begin
                if (start_lock) begin
                    cur_nxt.cnt = wr_count; // [R1]
                    cur_nxt.prescale = 4'h0;
                    cur_nxt.state = PLLTMR_LOCK; // [R4] [R13]
                end else begin
                    cur_nxt.state = PLLTMR_DIV;
                end
            end
            PLLTMR_LOCK: begin
                if (abort_lock) begin
                    cur_nxt.state = PLLTMR_DIV;
                end else if (cnt_zero) begin
                    cur_nxt.state = PLLTMR_PLL; // [R5]
                end else if (dec_now) begin
                    cur_nxt.cnt = cur_r.cnt - 8'h01; // [R1] [R3]
                end else begin
                    cur_nxt.state = PLLTMR_LOCK;
                end
            end
            PLLTMR_PLL: begin
                if (abort_lock) begin
                    cur_nxt.state = PLLTMR_DIV;
                end else begin
                    cur_nxt.state = PLLTMR_PLL;
                end
            end
            default: begin
                cur_nxt.state = PLLTMR_DIV;
            end
        endcase
        // The core leaves divide mode only once the timer has run out.
        if (cur_nxt.state == PLLTMR_PLL) begin
            cur_nxt.on_pll = 1'b1; // [R5]
        end else begin
            cur_nxt.on_pll = 1'b0;
        end
        // Either control bit keeps the oscillator running.
        if (cur_nxt.vco_force_on_bit || cur_nxt.pll_select_bit) begin
            cur_nxt.vco = 1'b1; // [R11]
        end else begin
            cur_nxt.vco = 1'b0;
        end
        cur_nxt.mult = calc_mult(cur_nxt.on_pll, cur_nxt.fraction_select_bit,
                                 cur_nxt.multiply_field); // [R10]
        // Read data stands for one cycle and is zero otherwise.
        if (rd_hit) begin
            cur_nxt.rdata = cur_word; // [R8] [R12]
        end else begin
            cur_nxt.rdata = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= RESET_STATE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Every output is a field of the state register.
    assign mmr_rdata = cur_r.rdata;
    assign vco_run = cur_r.vco;
    assign core_on_pll = cur_r.on_pll;
    assign mult_q = cur_r.mult;
    assign lock_count_now = cur_r.cnt;
endmodule

/* tb/plltmr_monitor.sv */
// Port checker for the lock timer block.
`timescale 1ns/100ps
module plltmr_monitor
    import plltmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] mmr_addr,
    input wire logic mmr_wr,
    input wire logic mmr_rd,
    input wire logic [15:0] mmr_wdata,
    input wire logic [15:0] mmr_rdata,
    input wire logic vco_run,
    input wire logic core_on_pll,
    input wire plltmr_pkg::plltmr_mult_t mult_q,
    input wire logic [7:0] lock_count_now
);
    import plltmr_pkg::*;
    logic sel_r;
    logic ws;
    assign ws = mmr_wr && mmr_addr == 7'h58;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            sel_r <= 1'b1;
        else if (ws)
            sel_r <= mmr_wdata[1];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_LOAD: assert property (ws && mmr_wdata[1] && !sel_r
        |=> lock_count_now == $past(mmr_wdata[10:3]) && !core_on_pll) else $error("bad load");
    AST_VCO: assert property (ws |=> vco_run == $past(mmr_wdata[2] | mmr_wdata[1]))
        else $error("bad vco");
    AST_HOLD: assert property (sel_r && !core_on_pll && lock_count_now != 8'h00 && !mmr_wr
        |=> !core_on_pll) else $error("early switch");
    AST_STEP: assert property (sel_r && !core_on_pll && !$past(mmr_wr)
        && $changed(lock_count_now) |-> lock_count_now == $past(lock_count_now) - 8'h01)
        else $error("bad step");
    AST_RATE: assert property (sel_r && !core_on_pll && !$past(mmr_wr)
        && $changed(lock_count_now) ##1 !mmr_wr [*8] |-> $past(lock_count_now, 8) == lock_count_now)
        else $error("fast step");
    AST_SWITCH: assert property (sel_r && !core_on_pll && lock_count_now == 8'h00
        && !mmr_wr |=> core_on_pll) else $error("no switch");
    AST_STATUS: assert property (mmr_rd && mmr_addr == 7'h58
        |=> mmr_rdata[0] == $past(core_on_pll)) else $error("bad status");
    AST_UNMAP: assert property (!(mmr_rd && mmr_addr == 7'h58) |=> mmr_rdata == 16'h0000)
        else $error("stray data");
endmodule
bind plltmr_top plltmr_monitor i_plltmr_monitor (.clk, .rst_n, .mmr_addr, .mmr_wr, .mmr_rd,
    .mmr_wdata, .mmr_rdata, .vco_run, .core_on_pll, .mult_q, .lock_count_now);

/* tb/plltmr_top_test.sv */
// Self-checking register sequence for the lock timer block.
`timescale 1ns/100ps
module plltmr_top_test;
    import plltmr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [6:0] mmr_addr = 7'h00;
    logic mmr_wr = 1'b0;
    logic mmr_rd = 1'b0;
    logic [15:0] mmr_wdata = 16'h0000;
    logic [15:0] mmr_rdata;
    logic vco_run;
    logic core_on_pll;
    plltmr_mult_t mult_q;
    logic [7:0] lock_count_now;
    int n_errors = 0;
    int n_compared = 0;
    localparam logic [7:0] LOCK_CNT = 8'(16000 / (16 * 5));
    plltmr_top i_plltmr_top (.clk, .rst_n, .mmr_addr, .mmr_wr, .mmr_rd, .mmr_wdata,
        .mmr_rdata, .vco_run, .core_on_pll, .mult_q, .lock_count_now);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clk);
        mmr_addr <= 7'h58;
        mmr_wdata <= d;
        mmr_wr <= 1'b1;
        @(posedge clk);
        mmr_wr <= 1'b0;
        wt(1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk);
        mmr_addr <= a;
        mmr_rd <= 1'b1;
        @(posedge clk);
        mmr_rd <= 1'b0;
        #1;
        chk(mmr_rdata, e);
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #30000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(7'h58, PLLTMR_RESET_WORD);
        chk({8'h00, mult_q}, 16'h0004);
        rd(7'h57, 16'h0000);
        wr(16'h0000);
        chk({6'h00, vco_run, core_on_pll, mult_q}, 16'h0002);
        wr(16'h201A);
        chk({lock_count_now, 7'h00, core_on_pll}, 16'h0300);
        wt(36);
        chk({lock_count_now, 7'h00, core_on_pll}, 16'h0100);
        wt(16);
        chk({lock_count_now, core_on_pll, mult_q[6:0]}, 16'h008C);
        rd(7'h58, 16'h201B);
        wr(16'h3802);
        chk({8'h00, mult_q}, 16'h0003);
        wr(16'h2802);
        chk({8'h00, mult_q}, 16'h0006);
        wr(16'hF000);
        chk({6'h00, vco_run, core_on_pll, mult_q}, 16'h0001);
        wr(16'hF004);
        chk({6'h00, vco_run, core_on_pll, mult_q}, 16'h0201);
        wr(16'h0002);
        wt(1);
        chk({6'h00, vco_run, core_on_pll, mult_q}, 16'h0304);
        wr(16'h0000);
        wr({5'h00, LOCK_CNT, 3'b010});
        chk({lock_count_now, 7'h00, core_on_pll}, {LOCK_CNT, 8'h00});
        wt(3199);
        chk({lock_count_now, 7'h00, core_on_pll}, 16'h0000);
        wt(1);
        chk({lock_count_now, 7'h00, core_on_pll}, 16'h0001);
        report_and_stop();
    end
endmodule
